// File: core/debug_exception_pkg.sv
package debug_exception_pkg;

	// ****************************************
	// debug and software breakpoint vectors
	// ****************************************
	localparam logic [7:0] debug_vector = 8'h01;
	localparam logic [7:0] soft_breakpoint_vector = 8'h03;

	// ****************************************
	// register byte offsets on the bus
	// ****************************************
	localparam logic [7:0] slot0_offset = 8'h00;
	localparam logic [7:0] slot1_offset = 8'h04;
	localparam logic [7:0] slot2_offset = 8'h08;
	localparam logic [7:0] slot3_offset = 8'h0c;
	localparam logic [7:0] debug_status_offset = 8'h18;
	localparam logic [7:0] debug_control_offset = 8'h1c;

	// ****************************************
	// debug status register fields
	// ****************************************
	localparam int slot_hit_pos = 0;
	localparam int access_detected_pos = 13;
	localparam int single_step_pos = 14;
	localparam int task_switch_pos = 15;
	localparam logic [31:0] debug_status_reset = 32'h0000_0000;

	// ****************************************
	// debug control register fields
	// ****************************************
	localparam int local_enable_pos = 0;
	localparam int global_enable_pos = 1;
	localparam int exact_local_pos = 8;
	localparam int exact_global_pos = 9;
	localparam int general_detect_pos = 13;
	localparam int access_type_pos = 16;
	localparam int length_pos = 18;
	localparam int slot_field_stride = 4;
	localparam logic [31:0] debug_control_reset = 32'h0000_0000;
	localparam logic [31:0] slot_reset = 32'h0000_0000;

	// ****************************************
	// field encodings
	// ****************************************
	localparam logic [1:0] type_execute = 2'h0;
	localparam logic [1:0] type_write = 2'h1;
	localparam logic [1:0] type_io = 2'h2;
	localparam logic [1:0] type_read_write = 2'h3;
	localparam logic [1:0] len_one = 2'h0;
	localparam logic [1:0] len_two = 2'h1;
	localparam logic [1:0] len_eight = 2'h2;
	localparam logic [1:0] len_four = 2'h3;

	// ****************************************
	// handler entries not raised by this unit
	// ****************************************
	typedef enum logic [1:0] {
		entry_fault,
		entry_interrupt,
		entry_soft_interrupt,
		entry_trap
	} entry_kind_t;

	// ****************************************
	// instructions that may carry a saved resume flag
	// ****************************************
	typedef enum logic [1:0] {
		load_wide_return,
		load_narrow_return,
		load_flags_pop
	} flag_load_kind_t;

endpackage

// File: core/debug_exception_unit.sv
`timescale 1ns/1ns
// Notes on behaviour
// - debug exceptions use vector 1, software breakpoints use vector 3
// - instruction breakpoint and general detect are faults, all others traps
// - one exception sets every matching cause flag of its class; trap causes in a faulting cycle are dropped
// - slot hit only when enabled; type 0 exec, 1 write, 2 io, 3 read/write
// - general detect sets access-detected flag as fault; task switch flag as trap
// - execution match on slot raises fault before the instruction runs
// - instruction breakpoint and general detect faults take priority over every other exception
// - breakpoint after a stack segment load may be suppressed
// - a set resume flag masks instruction breakpoint matches
// - resume flag clears at an instruction start that raises no fault, after the breakpoint check
// - task switch and wide return load resume flag; pops and narrow return do not
// - non-debug faults, and general detect faults without an instruction breakpoint hit in the same cycle, push resume flag as one
// - interrupt after a non-final string iteration pushes resume flag as one
// - trap from a non-final string iteration pushes resume flag as one
// - other entries push the current resume flag unchanged
// - resume flag leaves data and io breakpoints and other exceptions alone
// - data or io match on types 1 to 3 traps after the instruction
// - data trap raised only after the store has completed
// - exact enable bits are ignored, matching is always exact
// - repeated port strings trap after the iteration that hit
// - length code 00 one byte, 01 two, 11 four, 10 eight
// - data match when any accessed byte lies in the aligned slot range
// - general detect enable faults any debug register access attempt
// - single step traps after an instruction that ran with trap flag set
module debug_exception_unit (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// instruction start
	input wire logic instr_start,
	input wire logic [31:0] instr_addr,
	input wire logic instr_dbg_reg_access,
	input wire logic instr_after_ss_load,
	input wire logic trap_flag,
	// data and io accesses of the current instruction
	input wire logic data_valid,
	input wire logic [31:0] data_addr,
	input wire logic [1:0] data_len,
	input wire logic data_write,
	input wire logic data_io,
	input wire logic data_done,
	// instruction or string iteration completion
	input wire logic instr_retire,
	input wire logic rep_not_last,
	// task switch and resume flag loads
	input wire logic task_switch,
	input wire logic task_trap_bit,
	input wire logic task_resume_image,
	input wire logic flag_load,
	input wire logic [1:0] flag_load_kind,
	input wire logic flag_load_value,
	// software breakpoint and other handler entries
	input wire logic soft_bp,
	input wire logic other_entry,
	input wire logic [1:0] other_entry_kind,
	// exception dispatch
	output logic raise_valid,
	output logic [7:0] raise_vector,
	output logic raise_fault,
	output logic push_valid,
	output logic push_resume_flag,
	output logic resume_flag
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] range_mask(input logic [1:0] len);
		case (len)
			debug_exception_pkg::len_one: range_mask = 32'h0000_0000;
			debug_exception_pkg::len_two: range_mask = 32'h0000_0001;
			debug_exception_pkg::len_four: range_mask = 32'h0000_0003;
			debug_exception_pkg::len_eight: range_mask = 32'h0000_0007;
			default: range_mask = 32'h0000_0000;
		endcase
	endfunction

	// overlap of two aligned ranges; both bases are masked by the longer of the two lengths
	function automatic logic ranges_hit(input logic [31:0] slot, input logic [1:0] slen,
		input logic [31:0] addr, input logic [1:0] alen);
		logic [31:0] mask;
		mask = range_mask(slen) | range_mask(alen);
		ranges_hit = ((slot & ~mask) == (addr & ~mask));
	endfunction

	// ****************************************
	// register decode
	// ****************************************
	// one decode feeds every write enable, so no two registers can claim one offset
	function automatic logic [5:0] reg_select(input logic [7:0] adr);
		reg_select = 6'h00;
		case (adr)
			debug_exception_pkg::slot0_offset: reg_select = 6'h01;
			debug_exception_pkg::slot1_offset: reg_select = 6'h02;
			debug_exception_pkg::slot2_offset: reg_select = 6'h04;
			debug_exception_pkg::slot3_offset: reg_select = 6'h08;
			debug_exception_pkg::debug_status_offset: reg_select = 6'h10;
			debug_exception_pkg::debug_control_offset: reg_select = 6'h20;
			default: reg_select = 6'h00;
		endcase
	endfunction

	// ****************************************
	// registers
	// ****************************************
	logic [31:0] slot [4];
	logic [31:0] debug_control;
	logic [31:0] debug_status;
	logic [3:0] pending_hits;
	logic step_armed;
	logic bus_req;
	logic [31:0] rd_data;
	logic [3:0] exec_hits;
	logic [3:0] data_hits;
	logic bp_fault;
	logic gd_fault;
	logic any_fault;
	logic step_trap;
	logic task_trap;
	logic data_trap;
	logic any_trap;
	logic [31:0] status_set;
	logic [31:0] bus_wmask;
	logic [5:0] bus_sel;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_sel = reg_select(wb_adr_i);

	always_comb begin
		bus_wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	end

	// ****************************************
	// breakpoint matching
	// ****************************************
	always_comb begin
		exec_hits = 4'h0;
		data_hits = 4'h0;
		for (int n = 0; n < 4; n++) begin
			logic en;
			logic [1:0] kind;
			logic [1:0] len;
			en = debug_control[debug_exception_pkg::local_enable_pos + 2 * n]
				| debug_control[debug_exception_pkg::global_enable_pos + 2 * n];
			kind = debug_control[debug_exception_pkg::access_type_pos
				+ debug_exception_pkg::slot_field_stride * n +: 2];
			len = debug_control[debug_exception_pkg::length_pos
				+ debug_exception_pkg::slot_field_stride * n +: 2];
			// exact enables take no part in matching
			if (en && kind == debug_exception_pkg::type_execute && instr_start
				&& instr_addr == slot[n]) begin
				exec_hits[n] = 1'b1;
			end
			if (en && data_valid && ranges_hit(slot[n], len, data_addr, data_len)) begin
				case (kind)
					debug_exception_pkg::type_write: data_hits[n] = data_write & ~data_io;
					debug_exception_pkg::type_io: data_hits[n] = data_io;
					debug_exception_pkg::type_read_write: data_hits[n] = ~data_io;
					default: data_hits[n] = 1'b0;
				endcase
			end
		end
	end

	// ****************************************
	// exception classification
	// ****************************************
	always_comb begin
		// a set resume flag or a stack segment load masks only execution breakpoints
		bp_fault = (|exec_hits) & ~resume_flag & ~instr_after_ss_load;
		gd_fault = instr_start & instr_dbg_reg_access
			& debug_control[debug_exception_pkg::general_detect_pos];
		any_fault = bp_fault | gd_fault;
		// data and step traps wait for retire, and the data trap also waits for the store to be done
		data_trap = instr_retire & data_done & (|(pending_hits | data_hits));
		step_trap = instr_retire & step_armed;
		task_trap = task_switch & task_trap_bit;
		any_trap = data_trap | step_trap | task_trap;
		status_set = 32'h0000_0000;
		if (any_fault) begin
			status_set[debug_exception_pkg::slot_hit_pos +: 4] = bp_fault ? exec_hits : 4'h0;
			status_set[debug_exception_pkg::access_detected_pos] = gd_fault;
		end else if (any_trap) begin
			status_set[debug_exception_pkg::slot_hit_pos +: 4] = data_trap ? (pending_hits | data_hits) : 4'h0;
			status_set[debug_exception_pkg::single_step_pos] = step_trap;
			status_set[debug_exception_pkg::task_switch_pos] = task_trap;
		end
	end

	// ****************************************
	// wishbone slave
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_comb begin
		case (wb_adr_i)
			debug_exception_pkg::slot0_offset: rd_data = slot[0];
			debug_exception_pkg::slot1_offset: rd_data = slot[1];
			debug_exception_pkg::slot2_offset: rd_data = slot[2];
			debug_exception_pkg::slot3_offset: rd_data = slot[3];
			debug_exception_pkg::debug_status_offset: rd_data = debug_status;
			debug_exception_pkg::debug_control_offset: rd_data = debug_control;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= rd_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int n = 0; n < 4; n++) begin
				slot[n] <= debug_exception_pkg::slot_reset;
			end
		end else if (bus_req && wb_we_i) begin
			for (int n = 0; n < 4; n++) begin
				if (bus_sel[n]) begin
					slot[n] <= (slot[n] & ~bus_wmask) | (wb_dat_i & bus_wmask);
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			debug_control <= debug_exception_pkg::debug_control_reset;
		end else if (bus_req && wb_we_i && bus_sel[5]) begin
			debug_control <= (debug_control & ~bus_wmask) | (wb_dat_i & bus_wmask);
		end
	end

	// software may rewrite status, but a cause set in the same cycle still wins
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			debug_status <= debug_exception_pkg::debug_status_reset;
		end else if (bus_req && wb_we_i && bus_sel[4]) begin
			debug_status <= (debug_status & ~bus_wmask) | (wb_dat_i & bus_wmask) | status_set;
		end else begin
			debug_status <= debug_status | status_set;
		end
	end

	// ****************************************
	// per-instruction tracking
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pending_hits <= 4'h0;
		end else if (instr_retire || any_fault) begin
			pending_hits <= 4'h0;
		end else begin
			pending_hits <= pending_hits | data_hits;
		end
	end

	// trap flag sampled at start, so the instruction that sets it does not step
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			step_armed <= 1'b0;
		end else if (instr_start) begin
			step_armed <= trap_flag & ~any_fault;
		end else if (instr_retire) begin
			step_armed <= 1'b0;
		end
	end

	// ****************************************
	// resume flag
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			resume_flag <= 1'b0;
		end else if (task_switch) begin
			resume_flag <= task_resume_image;
		end else if (flag_load && flag_load_kind == debug_exception_pkg::load_wide_return) begin
			resume_flag <= flag_load_value;
		end else if (instr_start && !any_fault) begin
			resume_flag <= 1'b0;
		end
	end

	// ****************************************
	// dispatch and saved flag image
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			raise_valid <= 1'b0;
			raise_vector <= 8'h00;
			raise_fault <= 1'b0;
		end else if (any_fault || any_trap) begin
			raise_valid <= 1'b1;
			raise_vector <= debug_exception_pkg::debug_vector;
			raise_fault <= any_fault;
		end else if (soft_bp) begin
			raise_valid <= 1'b1;
			raise_vector <= debug_exception_pkg::soft_breakpoint_vector;
			raise_fault <= 1'b0;
		end else begin
			raise_valid <= 1'b0;
			raise_vector <= 8'h00;
			raise_fault <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			push_valid <= 1'b0;
			push_resume_flag <= 1'b0;
		end else if (any_fault) begin
			push_valid <= 1'b1;
			push_resume_flag <= bp_fault ? resume_flag : 1'b1;
		end else if (any_trap) begin
			push_valid <= 1'b1;
			push_resume_flag <= (instr_retire && rep_not_last) | resume_flag;
		end else if (soft_bp) begin
			push_valid <= 1'b1;
			push_resume_flag <= resume_flag;
		end else if (other_entry) begin
			push_valid <= 1'b1;
			case (other_entry_kind)
				debug_exception_pkg::entry_fault: push_resume_flag <= 1'b1;
				debug_exception_pkg::entry_interrupt, debug_exception_pkg::entry_trap:
					push_resume_flag <= rep_not_last | resume_flag;
				default: push_resume_flag <= resume_flag;
			endcase
		end else begin
			push_valid <= 1'b0;
			push_resume_flag <= 1'b0;
		end
	end

endmodule

// File: verif/debug_exception_chk.sv
`timescale 1ns/1ns
module debug_exception_chk (
	// watched ports
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic instr_start,
	input wire logic instr_dbg_reg_access,
	input wire logic instr_retire,
	input wire logic task_switch,
	input wire logic flag_load,
	input wire logic [1:0] flag_load_kind,
	input wire logic flag_load_value,
	input wire logic soft_bp,
	input wire logic other_entry,
	input wire logic [1:0] other_entry_kind,
	input wire logic raise_valid,
	input wire logic [7:0] raise_vector,
	input wire logic raise_fault,
	input wire logic push_valid,
	input wire logic push_resume_flag,
	input wire logic resume_flag
);
	// ****************************************
	// bus ack, dispatch and resume flag properties
	// ****************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	logic quiet;
	// no instruction start, retire or task switch, so no debug exception in the same cycle
	assign quiet = !instr_start && !instr_retire && !task_switch;
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered after one cycle");
	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	chk_soft_vector: assert property (soft_bp && quiet |=> raise_valid && raise_vector == 8'h03)
		else $error("software breakpoint not dispatched on its vector");
	chk_fault_cause: assert property (raise_valid && raise_fault |-> $past(instr_start))
		else $error("fault dispatched without an instruction start");
	chk_trap_cause: assert property (raise_valid && !raise_fault && raise_vector == 8'h01
		|-> $past(instr_retire) || $past(task_switch))
		else $error("debug trap dispatched without a completion or task switch");
	chk_rf_masks: assert property (instr_start && resume_flag && !instr_dbg_reg_access
		|=> !(raise_valid && raise_fault))
		else $error("instruction breakpoint taken while resume flag set");
	chk_rf_clears: assert property (instr_start && !instr_dbg_reg_access && !task_switch && !flag_load
		|=> !resume_flag)
		else $error("resume flag survived an instruction start");
	chk_rf_wide: assert property (flag_load && flag_load_kind == 2'h0 && quiet
		|=> resume_flag == $past(flag_load_value))
		else $error("wide return did not load the resume flag");
	chk_rf_narrow: assert property (flag_load && flag_load_kind != 2'h0 && quiet |=> $stable(resume_flag))
		else $error("narrow return or pop changed the resume flag");
	chk_fault_push: assert property (other_entry && other_entry_kind == 2'h0 && quiet && !soft_bp
		|=> push_valid && push_resume_flag)
		else $error("fault entry did not push resume flag as one");
	chk_soft_push: assert property (other_entry && other_entry_kind == 2'h2 && quiet && !soft_bp
		|=> push_valid && push_resume_flag == $past(resume_flag))
		else $error("software interrupt entry changed the pushed resume flag");
	cover property (raise_valid && raise_fault);
	cover property (raise_valid && !raise_fault);
	cover property (flag_load && quiet ##1 resume_flag);
endmodule
bind debug_exception_unit debug_exception_chk debug_exception_chk_i (
	.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .instr_start, .instr_dbg_reg_access,
	.instr_retire, .task_switch, .flag_load, .flag_load_kind, .flag_load_value, .soft_bp,
	.other_entry, .other_entry_kind, .raise_valid, .raise_vector, .raise_fault, .push_valid,
	.push_resume_flag, .resume_flag
);

// File: verif/pipe_model.sv
`timescale 1ns/1ns
module pipe_model (
	// clock and command
	input wire logic ref_clk,
	input wire logic go,
	input wire logic [31:0] pc,
	input wire logic [31:0] dadr,
	input wire logic [1:0] dlen,
	input wire logic dwr,
	// pipeline side of the unit
	output logic instr_start,
	output logic [31:0] instr_addr,
	output logic data_valid,
	output logic [31:0] data_addr,
	output logic [1:0] data_len,
	output logic data_write,
	output logic instr_retire,
	output logic data_done
);
	// ****************************************
	// one instruction: start, one access, retire
	// ****************************************
	logic [1:0] step;
	initial begin
		step = 2'h0;
		{instr_start, data_valid, instr_retire, data_done, data_write} = 5'h00;
		{instr_addr, data_addr, data_len} = '0;
	end
	always @(posedge ref_clk) begin
		instr_start <= go && step == 2'h0;
		data_valid <= step == 2'h1;
		instr_retire <= step == 2'h2;
		data_done <= step == 2'h2;
		// released lines flip each cycle so a stale value never passes for a live one
		instr_addr <= (go && step == 2'h0) ? pc : ~instr_addr;
		data_addr <= step == 2'h1 ? dadr : ~data_addr;
		data_len <= step == 2'h1 ? dlen : ~data_len;
		data_write <= step == 2'h1 ? dwr : ~data_write;
		step <= (go || step != 2'h0) ? step + 2'h1 : 2'h0;
	end
endmodule

// File: verif/debug_exception_unit_test.sv
`timescale 1ns/1ns
module debug_exception_unit_test;
	logic ref_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dwr, data_io, data_done;
	logic instr_start, instr_dbg_reg_access, instr_after_ss_load, trap_flag, data_valid, data_write;
	logic instr_retire, rep_not_last, task_trap_bit, task_resume_image, flag_load_value;
	logic raise_valid, raise_fault, push_valid, push_resume_flag, resume_flag;
	logic [7:0] wb_adr_i, raise_vector;
	logic [3:0] wb_sel_i;
	logic [4:0] pl;
	logic [31:0] wb_dat_i, wb_dat_o, instr_addr, data_addr, pc, dadr, a, rd;
	logic [1:0] data_len, flag_load_kind, other_entry_kind, dlen;
	wire go, soft_bp, flag_load, other_entry, task_switch;
	int mismatches, cmp_count;
	logic last_push;
	logic [8:0] exp_q[$];
	assign {go, soft_bp, flag_load, other_entry, task_switch} = pl;
	debug_exception_unit debug_exception_unit_i (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_start, .instr_addr,
		.instr_dbg_reg_access, .instr_after_ss_load, .trap_flag, .data_valid, .data_addr, .data_len,
		.data_write, .data_io, .data_done, .instr_retire, .rep_not_last, .task_switch, .task_trap_bit,
		.task_resume_image, .flag_load, .flag_load_kind, .flag_load_value, .soft_bp, .other_entry,
		.other_entry_kind, .raise_valid, .raise_vector, .raise_fault, .push_valid, .push_resume_flag,
		.resume_flag);
	pipe_model pipe_model_i (.ref_clk, .go, .pc, .dadr, .dlen, .dwr, .instr_start, .instr_addr,
		.data_valid, .data_addr, .data_len, .data_write, .instr_retire, .data_done);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ****************************************
	// shared tasks and dispatch monitor
	// ****************************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, adr, d, 4'hf};
		for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++)
			@(posedge ref_clk);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (n == 20) begin
			mismatches++;
			test_done();
		end
	endtask
	task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		check("read data", exp, rd);
	endtask
	// each pulse lasts one cycle; the partner needs four, dispatch lands within them
	task automatic pulse(input logic [4:0] p);
		@(posedge ref_clk);
		pl <= p;
		@(posedge ref_clk);
		pl <= 5'h00;
		repeat (5) @(posedge ref_clk);
		check("pending dispatch", 32'h0, 32'(exp_q.size()));
	endtask
	always @(posedge ref_clk) begin
		if (push_valid === 1'b1)
			last_push <= push_resume_flag;
	end
	always @(posedge ref_clk) begin
		if (raise_valid === 1'b1) begin
			if (exp_q.size() == 0)
				check("raise_valid", 32'h0, 32'h1);
			else
				check("dispatch", {23'h0, exp_q.pop_front()}, {23'h0, raise_vector, raise_fault});
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i, pl} = {4'h8, 49'h0};
		{pc, dadr, dlen, dwr, flag_load_kind, other_entry_kind, flag_load_value} = '0;
		{instr_dbg_reg_access, instr_after_ss_load, trap_flag, data_io, rep_not_last} = 5'h00;
		{task_trap_bit, task_resume_image, mismatches, cmp_count} = '0;
		void'($urandom(63));
		a = $urandom & 32'hffff_f000;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdc(8'h18, 32'h0);
		rdc(8'h1c, 32'h0);
		wb(1'b1, 8'h40, 32'hffff_ffff);
		rdc(8'h40, 32'h0);
		$display("test reset done");
		wb(1'b1, 8'h00, a);
		wb(1'b1, 8'h04, a + 32'h100);
		wb(1'b1, 8'h1c, 32'h00d0_0009);
		rdc(8'h1c, 32'h00d0_0009);
		{pc, dadr, dwr} = {a, a + 32'h104, 1'b1};
		exp_q.push_back(9'h003);
		pulse(5'h10);
		rdc(8'h18, 32'h1);
		$display("test execute done");
		{task_trap_bit, task_resume_image} = 2'h3;
		exp_q.push_back(9'h002);
		pulse(5'h01);
		check("resume_flag", 32'h1, {31'h0, resume_flag});
		rdc(8'h18, 32'h8001);
		{flag_load_kind, flag_load_value} = 3'h2;
		pulse(5'h04);
		check("resume_flag", 32'h1, {31'h0, resume_flag});
		pulse(5'h10);
		check("resume_flag", 32'h0, {31'h0, resume_flag});
		{flag_load_kind, flag_load_value} = 3'h1;
		pulse(5'h04);
		check("resume_flag", 32'h1, {31'h0, resume_flag});
		$display("test resume done");
		wb(1'b1, 8'h18, 32'h0);
		{pc, dadr, dlen} = {a + 32'h10, a + 32'h102, 2'h0};
		exp_q.push_back(9'h002);
		pulse(5'h10);
		rdc(8'h18, 32'h2);
		check("resume_flag", 32'h0, {31'h0, resume_flag});
		$display("test data done");
		exp_q.push_back(9'h006);
		pulse(5'h08);
		other_entry_kind <= 2'h0;
		pulse(5'h02);
		check("push_resume_flag", 32'h1, {31'h0, last_push});
		other_entry_kind <= 2'h2;
		pulse(5'h02);
		check("push_resume_flag", 32'h0, {31'h0, last_push});
		{other_entry_kind, rep_not_last} <= 3'h3;
		pulse(5'h02);
		check("push_resume_flag", 32'h1, {31'h0, last_push});
		rep_not_last <= 1'b0;
		$display("test entries done");
		wb(1'b1, 8'h18, 32'h0);
		{pc, dadr, trap_flag} <= {a + 32'h20, a + 32'h200, 1'b1};
		exp_q.push_back(9'h002);
		pulse(5'h10);
		trap_flag <= 1'b0;
		rdc(8'h18, 32'h4000);
		wb(1'b1, 8'h1c, 32'h00d0_2009);
		{pc, instr_dbg_reg_access} <= {a + 32'h30, 1'b1};
		exp_q.push_back(9'h003);
		pulse(5'h10);
		instr_dbg_reg_access <= 1'b0;
		rdc(8'h18, 32'h6000);
		$display("test detect done");
		test_done();
	end
endmodule
